//--- hdl/scs_consts.svh
// Constants of the SPI command frame slave
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH
`define SCS_FLEN 5'h10
`define SCS_LOW_START 5'h07
`define SCS_ADDR_DONE 5'h06
`define SCS_FLAG_ADDR 5'h11
`define SCS_FLAG_BIT 4
`define SCS_RST_BYTE 8'h00
`define SCS_CLK_NS 40
`define SCS_LEAD_MAX_NS 2500
`define SCS_LEAD_MIN_NS 550
`define SCS_LEAD_MIN_LATE_NS 30
`define SCS_CSLOW_NS 5500
`define SCS_STUCK_NS 2000000
`endif

//--- hdl/scs_pkg.sv
// Types of the SPI command frame slave
package scs_pkg;
   typedef enum logic [1:0] {
      SCS_IDLE = 2'b00,
      SCS_LEAD = 2'b01,
      SCS_SHIFT = 2'b10
   } scs_state_t;

   typedef enum logic [1:0] {
      SCS_OP_READ = 2'b00,
      SCS_OP_WRITE = 2'b01,
      SCS_OP_RSVD = 2'b10,
      SCS_OP_FLAG = 2'b11
   } scs_op_t;

   typedef struct packed {
      scs_op_t op;
      logic [4:0] addr;
      logic parNext;
      logic [7:0] data;
   } scs_cmd_t;

   typedef struct packed {
      logic [2:0] sclkSy;
      logic [2:0] csSy;
      logic [1:0] mosiSy;
      scs_state_t st;
      logic [4:0] rise;
      logic [4:0] fall;
      scs_cmd_t rx;
      logic [7:0] fix;
      logic [7:0] low;
      logic [6:0] lead;
      logic leadOk;
      logic [7:0] dur;
      logic [19:0] stuckCnt;
      logic stuck;
      logic pend;
      logic [12:0] pendCmd;
      logic [31:0][7:0] regs;
      logic miso;
      logic misoOe;
      logic wrStb;
      logic [4:0] wrAddr;
      logic [7:0] wrData;
      logic drop;
   } scs_st_t;
endpackage : scs_pkg

//--- hdl/scs_spi_slave.sv
// SPI command frame slave with missed-write completion and stuck-select guard
// Behaviour
// - Each command is exactly sixteen bits on MOSI and on MISO.
// - MOSI bits 15..14 select write, read back or flag read.
// - MOSI bits 13..9 carry the five-bit register address.
// - Bit 8 is parity on writes, next bit (one) on reads.
// - MOSI bits 7..0 carry the write data byte.
// - MISO bits 15..8 return the fixed status byte every frame.
// - MISO bits 7..0 return extended status, register content or flags.
// - No pass-through to further slaves; own chip select per device.
// - An unaccepted write is completed at the end of the next accepted frame.
// - Read frames (00, 11) never suffer the missed-write effect.
// - Select low for more than 2.0 ms sets the stuck-low flag.
// - With flag set, writes need lead time within the allowed window.
// - Flag read at address 0x11 reports the stuck flag in bit 4.
// - Reading the flag clears it, lifting the lead time limit.
// - Lead time runs from select fall to first clock edge.
// - Writes return status then extended status; read-backs return register content, flag reads the flags.
`timescale 1ns/1ps
`default_nettype none
`include "scs_consts.svh"
module scs_spi_slave #(
   parameter int STUCK_CYC = `SCS_STUCK_NS / `SCS_CLK_NS,
   parameter bit LATE_VER = 1'b0,
   parameter bit AFFECTED = 1'b1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclk,
   input wire logic csN,
   input wire logic mosi,
   input wire logic parityEn,
   input wire logic [7:0] fixedStatus,
   input wire logic [7:0] extStatus,
   input wire logic [7:0] flagsIn,
   output logic miso,
   output logic misoOe,
   output logic wrStrobe,
   output logic [4:0] wrAddr,
   output logic [7:0] wrData,
   output logic stuckFlag,
   output logic frameDrop
);
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int LEAD_MAX_CYC = `SCS_LEAD_MAX_NS / `SCS_CLK_NS;
   localparam int LEAD_MIN_NS = LATE_VER ? `SCS_LEAD_MIN_LATE_NS : `SCS_LEAD_MIN_NS;
   localparam int LEAD_MIN_CYC = (LEAD_MIN_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS;
   localparam int CSLOW_CYC = (`SCS_CSLOW_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS;

   if (STUCK_CYC < 1 || STUCK_CYC >= (1 << 20)) begin : g_chk
      $error("STUCK_CYC out of range");
   end

   scs_pkg::scs_st_t q;
   scs_pkg::scs_st_t n;
   logic rise;
   logic fall;
   logic csFall;
   logic csRise;
   logic csLow;
   logic mosiS;
   logic [4:0] nf;
   logic frameOk;
   logic doWrite;
   logic [7:0] flagByte;
   scs_pkg::scs_cmd_t nrx;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      n = q;
      n.wrStb = 1'b0;
      n.drop = 1'b0;
      // First stage feeds only the second; edges come from later stages
      n.sclkSy = {q.sclkSy[1:0], sclk};
      n.csSy = {q.csSy[1:0], csN};
      n.mosiSy = {q.mosiSy[0], mosi};
      rise = q.sclkSy[1] & ~q.sclkSy[2];
      fall = ~q.sclkSy[1] & q.sclkSy[2];
      csLow = ~q.csSy[1];
      csFall = ~q.csSy[1] & q.csSy[2];
      csRise = q.csSy[1] & ~q.csSy[2];
      mosiS = q.mosiSy[1];
      nf = 5'(q.fall + 5'h01);
      nrx = scs_pkg::scs_cmd_t'({q.rx[14:0], mosiS});
      flagByte = flagsIn;
      flagByte[`SCS_FLAG_BIT] = q.stuck;
      frameOk = 1'b0;
      doWrite = 1'b0;

      if (csLow) begin
         if (q.stuckCnt < 20'(STUCK_CYC)) begin
            n.stuckCnt = 20'(q.stuckCnt + 20'h0_0001);
         end
      end else begin
         n.stuckCnt = 20'h0_0000;
      end

      case (q.st)
         scs_pkg::SCS_IDLE: begin
            n.misoOe = 1'b0;
            n.miso = 1'b0;
            if (csFall) begin
               n.st = scs_pkg::SCS_LEAD;
               n.rise = 5'h00;
               n.fall = 5'h00;
               n.lead = 7'h00;
               n.dur = 8'h00;
               n.fix = fixedStatus;
               n.low = extStatus;
               n.misoOe = 1'b1;
               n.miso = fixedStatus[7];
            end
         end
         scs_pkg::SCS_LEAD, scs_pkg::SCS_SHIFT: begin
            if (q.dur != 8'hff) begin
               n.dur = 8'(q.dur + 8'h01);
            end
            if (q.st == scs_pkg::SCS_LEAD && q.lead != 7'h7f) begin
               n.lead = 7'(q.lead + 7'h01);
            end
            if (rise) begin
               n.st = scs_pkg::SCS_SHIFT;
               n.rx = nrx;
               if (q.rise != 5'h1f) begin
                  n.rise = 5'(q.rise + 5'h01);
               end
               if (q.st == scs_pkg::SCS_LEAD) begin
                  // Lead counter starts one cycle after the synced fall
                  n.leadOk = (q.lead >= 7'(LEAD_MIN_CYC - 1)) && (q.lead < 7'(LEAD_MAX_CYC));
               end
               if (q.rise == `SCS_ADDR_DONE) begin
                  // Opcode and address are complete at the seventh edge
                  case (nrx[6:5])
                     scs_pkg::SCS_OP_READ: n.low = q.regs[nrx[4:0]];
                     scs_pkg::SCS_OP_FLAG: n.low = (nrx[4:0] == `SCS_FLAG_ADDR) ? flagByte : flagsIn;
                     default: n.low = extStatus;
                  endcase
               end
            end
            if (fall && q.st == scs_pkg::SCS_SHIFT && q.fall < `SCS_FLEN) begin
               n.fall = nf;
               if (nf < `SCS_FLEN) begin
                  n.miso = (nf < 5'h08) ? q.fix[~nf[2:0]] : q.low[~nf[2:0]];
               end
            end
            if (csRise) begin
               n.st = scs_pkg::SCS_IDLE;
               n.misoOe = 1'b0;
               n.miso = 1'b0;
               case (q.rx.op)
                  scs_pkg::SCS_OP_READ, scs_pkg::SCS_OP_FLAG: frameOk = q.rx.parNext;
                  scs_pkg::SCS_OP_WRITE: frameOk = ~parityEn
                     | (q.rx.parNext == ^{q.rx.op, q.rx.addr, q.rx.data});
                  default: frameOk = 1'b1;
               endcase
               frameOk = frameOk && (q.rise == `SCS_FLEN);
               n.drop = ~frameOk;
               if (frameOk) begin
                  doWrite = (q.rx.op == scs_pkg::SCS_OP_WRITE) && (~q.stuck || q.leadOk);
                  if (q.pend) begin
                     // Earlier write finishes now, whatever this frame is
                     n.pend = 1'b0;
                     n.wrStb = 1'b1;
                     n.wrAddr = q.pendCmd[12:8];
                     n.wrData = q.pendCmd[7:0];
                     n.regs[q.pendCmd[12:8]] = q.pendCmd[7:0];
                  end
                  if (doWrite) begin
                     // Short select or a slot already taken leaves it pending
                     // Duration counter also lags the select by one cycle
                     if ((AFFECTED && q.dur < 8'(CSLOW_CYC - 1)) || q.pend) begin
                        n.pend = 1'b1;
                        n.pendCmd = {q.rx.addr, q.rx.data};
                     end else begin
                        n.wrStb = 1'b1;
                        n.wrAddr = q.rx.addr;
                        n.wrData = q.rx.data;
                        n.regs[q.rx.addr] = q.rx.data;
                     end
                  end
                  if (q.rx.op == scs_pkg::SCS_OP_FLAG && q.rx.addr == `SCS_FLAG_ADDR) begin
                     n.stuck = 1'b0;
                  end
               end
            end
         end
         default: n.st = scs_pkg::SCS_IDLE;
      endcase

      // Set after clear: a stuck event in the clearing cycle survives
      if (csLow && q.stuckCnt >= 20'(STUCK_CYC)) begin
         n.stuck = 1'b1;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= '0;
         q.sclkSy <= 3'h0;
         q.csSy <= 3'h7;
         q.st <= scs_pkg::SCS_IDLE;
         q.regs <= {32{`SCS_RST_BYTE}};
      end else begin
         q <= n;
      end
   end

   assign miso = q.miso;
   assign misoOe = q.misoOe;
   assign wrStrobe = q.wrStb;
   assign wrAddr = q.wrAddr;
   assign wrData = q.wrData;
   assign stuckFlag = q.stuck;
   assign frameDrop = q.drop;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence selFall;
      q.st == scs_pkg::SCS_IDLE ##1 q.st == scs_pkg::SCS_LEAD;
   endsequence

   sequence directWrite;
      q.wrStb && !$past(q.pend);
   endsequence

   AST_FIX_FIRST: assert property (selFall |-> misoOe && miso == q.fix[7])
      else $error("First status bit not driven");
   AST_FIX_BYTE: assert property (q.st == scs_pkg::SCS_SHIFT && q.fall < 5'h08 && q.misoOe
      |-> miso == q.fix[~q.fall[2:0]])
      else $error("Fixed status bit wrong");
   AST_LOW_BYTE: assert property (q.st == scs_pkg::SCS_SHIFT && q.fall >= 5'h08 && q.fall < `SCS_FLEN
      |-> miso == q.low[~q.fall[2:0]])
      else $error("Low byte bit wrong");
   AST_LEN: assert property (q.wrStb |-> q.rise == `SCS_FLEN && q.st == scs_pkg::SCS_IDLE)
      else $error("Write from a short frame");
   AST_OPCODE: assert property (directWrite |-> q.rx.op == scs_pkg::SCS_OP_WRITE)
      else $error("Write from non-write opcode");
   AST_FIELDS: assert property (directWrite |-> wrAddr == q.rx.addr && wrData == q.rx.data
      && q.regs[q.rx.addr] == q.rx.data)
      else $error("Write fields wrong");
   AST_GATE: assert property (directWrite and $past(q.stuck) |-> q.leadOk)
      else $error("Write taken outside lead window");
   AST_PEND_DONE: assert property ($fell(q.pend) |-> q.wrStb)
      else $error("Pending write lost");
   AST_READ_NOPEND: assert property ($rose(q.pend) |-> q.rx.op == scs_pkg::SCS_OP_WRITE)
      else $error("Read frame left pending");
   AST_STUCK: assert property (csLow && q.stuckCnt >= 20'(STUCK_CYC) |=> stuckFlag)
      else $error("Stuck flag not set");
endmodule : scs_spi_slave
`default_nettype wire

//--- dv/scs_master_model.sv
// SPI master model that drives the command frames
`timescale 1ns/1ps
`default_nettype none
module scs_master_model (
   input wire logic clk_sys,
   input wire logic miso,
   output logic sclk,
   output logic csN,
   output logic mosi
);
   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      mosi = 1'b0;
   end
   // Entered at a falling clk_sys edge; mode 0, MSB first
   task automatic frame(input logic [15:0] w, input int lead, input int n, input int tail, output logic [15:0] r);
      logic [15:0] sh;
      r = 16'h0000;
      sh = {w[14:0], ~w[0]};
      csN = 1'b0;
      mosi = w[15];
      repeat (lead) @(negedge clk_sys);
      for (int i = 0; i < n; i++) begin
         sclk = 1'b1;
         repeat (4) @(negedge clk_sys);
         r = {r[14:0], miso};
         sclk = 1'b0;
         mosi = sh[15];
         sh = sh << 1;
         repeat (4) @(negedge clk_sys);
      end
      repeat (tail) @(negedge clk_sys);
      csN = 1'b1;
      mosi = ~mosi;
   endtask : frame
endmodule : scs_master_model
`default_nettype wire

//--- dv/scs_spi_slave_test.sv
// Self-checking bench for the SPI command frame slave
`timescale 1ns/1ps
`default_nettype none
module scs_spi_slave_test;
   localparam int STK = 240;
   logic clk_sys, rst, sclk, csN, mosi, parityEn, miso, misoOe, wrStrobe, stuckFlag, frameDrop;
   logic [7:0] fixedStatus, extStatus, flagsIn, wrData, rd, pD;
   logic [4:0] wrAddr, ra, pA;
   logic [15:0] w;
   logic [7:0] regs [32];
   bit pend, stuck;
   int failures, testsRun, nStb, nDrop, nOe, seed;
   scs_spi_slave #(.STUCK_CYC(STK), .LATE_VER(1'b0), .AFFECTED(1'b1)) scs_spi_slave_i (.clk_sys(clk_sys),
      .rst(rst), .sclk(sclk), .csN(csN), .mosi(mosi), .parityEn(parityEn), .fixedStatus(fixedStatus),
      .extStatus(extStatus), .flagsIn(flagsIn), .miso(miso), .misoOe(misoOe), .wrStrobe(wrStrobe),
      .wrAddr(wrAddr), .wrData(wrData), .stuckFlag(stuckFlag), .frameDrop(frameDrop));
   scs_master_model scs_master_model_i (.clk_sys(clk_sys), .miso(miso), .sclk(sclk), .csN(csN), .mosi(mosi));
   // ----------------------------------------
   // Checking and reference model
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      testsRun++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("failures %0d of %0d checks", failures, testsRun);
      if (failures == 0 && testsRun > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   always @(posedge clk_sys) begin
      if (wrStrobe === 1'b1) nStb++;
      if (frameDrop === 1'b1) nDrop++;
      if (misoOe === 1'b1) nOe++;
   end
   task automatic xfer(input logic [15:0] cw, input int lead, input int n, input int tail);
      logic [15:0] r;
      logic [7:0] lo, eD;
      logic [4:0] a, eA;
      logic [1:0] op;
      int low;
      bit drop, eS, hadPend;
      @(negedge clk_sys);
      fixedStatus = $random(seed);
      extStatus = $random(seed);
      flagsIn = $random(seed);
      op = cw[15:14];
      a = cw[13:9];
      low = lead + 8 * n + tail;
      lo = (op == 2'b00) ? regs[a] : (op == 2'b11) ? flagsIn : extStatus;
      if (op == 2'b11 && a == 5'h11) lo[4] = stuck;
      nStb = 0;
      nDrop = 0;
      nOe = 0;
      scs_master_model_i.frame(cw, lead, n, tail, r);
      repeat (10) @(negedge clk_sys);
      if (low > STK) stuck = 1'b1;
      drop = (n != 16) || (op != 2'b01 && op != 2'b10 && !cw[8]);
      drop = drop || (op == 2'b01 && parityEn && cw[8] !== ^{cw[15:9], cw[7:0]});
      eS = 1'b0;
      hadPend = pend;
      if (!drop) begin
         if (pend) begin
            {eS, eA, eD, pend} = {1'b1, pA, pD, 1'b0};
            regs[pA] = pD;
         end
         if (op == 2'b01 && !(stuck && (lead < 14 || lead > 62))) begin
            if (low < 138 || hadPend) {pend, pA, pD} = {1'b1, a, cw[7:0]};
            else begin
               {eS, eA, eD} = {1'b1, a, cw[7:0]};
               regs[a] = eD;
            end
         end
         if (op == 2'b11 && a == 5'h11) stuck = 1'b0;
      end
      if (n == 16) chk(r, {fixedStatus, lo});
      chk(16'(nDrop), {15'h0000, drop});
      chk(16'(nStb), {15'h0000, eS});
      if (eS) chk({3'h0, wrAddr, wrData}, {3'h0, eA, eD});
      chk(16'(nOe), 16'(low));
      chk({14'h0000, stuckFlag, misoOe}, {14'h0000, stuck, 1'b0});
   endtask : xfer
   // ----------------------------------------
   // Clock, stimulus and watchdog
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (40000) @(posedge clk_sys);
      failures++;
      stop_test();
   end
   initial begin
      seed = 32'h2666;
      {rst, parityEn, pend, stuck} = 4'h8;
      {fixedStatus, extStatus, flagsIn} = 24'h00_0000;
      foreach (regs[i]) regs[i] = 8'h00;
      repeat (12) @(negedge clk_sys);
      rst = 1'b0;
      chk({misoOe, stuckFlag, wrStrobe, wrAddr, wrData}, 16'h0000);
      for (int k = 0; k < 8; k++) begin
         ra = $random(seed);
         rd = $random(seed);
         parityEn = k[0];
         w = {2'b01, ra, 1'b0, rd};
         w[8] = ^w ^ (k == 3);
         xfer(w, 20, 16, 20);
         xfer({2'b00, ra, 1'b1, 8'h00}, 20, 16, 20);
      end
      parityEn = 1'b0;
      xfer(16'h0400, 20, 16, 20);
      xfer(16'h8300, 20, 16, 20);
      xfer(16'h64A5, 20, 15, 20);
      // Short select on purpose so the write is held back
      xfer(16'h66C0, 6, 16, 0);
      xfer(16'h2580, 20, 16, 20);
      xfer(16'h2700, 20, 16, 20);
      // Select just below and at the 5.5 us limit; a write after a pending one waits too
      xfer(16'h6CAA, 9, 16, 0);
      xfer(16'h6D55, 10, 16, 0);
      xfer(16'h2D00, 20, 16, 20);
      xfer(16'h2D00, 20, 16, 20);
      xfer(16'h6C11, 10, 16, 0);
      xfer(16'h2D00, 20, 16, 20);
      xfer(16'h0000, 300, 0, 0);
      xfer(16'h605A, 80, 16, 20);
      xfer(16'h60C0, 20, 16, 20);
      // Lead window edges while the stuck flag is up
      xfer(16'h6A33, 63, 16, 20);
      xfer(16'h6A33, 62, 16, 20);
      xfer(16'h6A44, 13, 16, 20);
      xfer(16'h2B00, 20, 16, 20);
      xfer(16'h6A44, 14, 16, 20);
      xfer(16'hE300, 20, 16, 20);
      xfer(16'h605A, 80, 16, 20);
      xfer(16'h2100, 20, 16, 20);
      xfer(16'h2B00, 20, 16, 20);
      stop_test();
   end
endmodule : scs_spi_slave_test
`default_nettype wire
